// ### ofa_pkg.sv
// Package: register map, field layout, reset values and timing for the optical sampling control
package ofa_pkg;

   localparam logic [7:0] OFA_SYS_CTRL_ADDR = 8'h0D;
   localparam logic [7:0] OFA_CFG1_ADDR = 8'h0E;
   localparam logic [7:0] OFA_CFG2_ADDR = 8'h0F;

   localparam int OFA_SOFT_RESET_BIT = 0;
   localparam int OFA_POWER_SAVE_BIT = 1;
   localparam int OFA_LP_BIT = 3;
   localparam int OFA_RANGE_LSB = 6;
   localparam int OFA_RATE_LSB = 2;
   localparam int OFA_TINT_LSB = 0;
   localparam int OFA_SETTLE_LSB = 3;

   localparam logic [7:0] OFA_SYS_CTRL_RST = 8'h00;
   localparam logic [7:0] OFA_SYS_CTRL_MASK = 8'h1F;
   localparam logic [7:0] OFA_CFG1_RST = 8'h00;
   localparam logic [7:0] OFA_CFG2_RST = 8'h18;
   localparam logic [7:0] OFA_CFG2_MASK = 8'h1F;

   // Rate codes: single pulse 0..A, dual pulse B..F
   localparam logic [3:0] OFA_RATE_100 = 4'h4;
   localparam logic [3:0] OFA_RATE_200 = 4'h5;
   localparam logic [3:0] OFA_RATE_400 = 4'h6;
   localparam logic [3:0] OFA_RATE_800 = 4'h7;
   localparam logic [3:0] OFA_RATE_1000 = 4'h8;
   localparam logic [3:0] OFA_RATE_1600 = 4'h9;
   localparam logic [3:0] OFA_RATE_3200 = 4'hA;
   localparam logic [3:0] OFA_DUAL_FIRST = 4'hB;
   localparam logic [3:0] OFA_DUAL_25 = 4'hC;
   localparam logic [3:0] OFA_DUAL_50 = 4'hD;
   localparam logic [3:0] OFA_DUAL_84 = 4'hE;
   localparam logic [3:0] OFA_DUAL_100 = 4'hF;

   localparam int unsigned OFA_RATE_SPS [16] = '{20, 25, 50, 84, 100, 200, 400, 800, 1000, 1600, 3200,
                                                  20, 25, 50, 84, 100};
   localparam int unsigned OFA_TINT_NS [4] = '{52000, 104000, 206000, 417000};
   localparam int unsigned OFA_SETTLE_NS [4] = '{2500000, 5000000, 10000000, 20000000};
   localparam int unsigned OFA_RES_BITS [4] = '{16, 17, 18, 19};
   localparam int unsigned OFA_MAX_RES_BITS = 19;
   // Half a 100 Hz mains period between the two pulses of a dual-pulse sample
   localparam int unsigned OFA_DUAL_GAP_NS = 5000000;
   localparam logic [2:0] OFA_RESET_SEQ_CYCLES = 3'h4;

   typedef enum logic [2:0] {
      OFA_ST_IDLE = 3'b000,
      OFA_ST_SETTLE = 3'b001,
      OFA_ST_INTEG = 3'b010,
      OFA_ST_GAP = 3'b011,
      OFA_ST_SHUT = 3'b100
   } ofa_state_e;

   // Least time: rounds up, never below one cycle
   function automatic logic [31:0] ofa_cycles_up(input int unsigned ns, input int unsigned mhz);
      longint unsigned c;
      c = (longint'(ns) * longint'(mhz) + 64'd999) / 64'd1000;
      if (c == 64'd0) begin
         c = 64'd1;
      end
      return c[31:0];
   endfunction

   function automatic logic [31:0] ofa_period(input logic [3:0] code, input int unsigned mhz);
      longint unsigned c;
      c = (longint'(mhz) * 64'd1000000) / longint'(OFA_RATE_SPS[code]);
      return c[31:0];
   endfunction

endpackage

// ### ofa_rate_limit.sv
// Rate clamp: substitutes the highest supported rate for an invalid setting
`timescale 1ns/1ps
`default_nettype none
module ofa_rate_limit
   import ofa_pkg::*;
(
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic [3:0] rate_req_i,
   input wire logic [1:0] tint_i,
   input wire logic [2:0] items_i,
   input wire logic lp_i,
   output logic [3:0] rate_eff_o
);

   logic [3:0] max_code;
   logic [2:0] items;

   always_comb begin
      // No items enabled is checked as one item so the field still reads sensibly
      items = (items_i == 3'h0) ? 3'h1 : items_i;
      max_code = OFA_RATE_3200;
      if (rate_req_i < OFA_DUAL_FIRST) begin
         case ({items, tint_i})
            {3'h1, 2'h0}: max_code = OFA_RATE_3200;
            {3'h1, 2'h1}, {3'h1, 2'h2}, {3'h2, 2'h0}: max_code = OFA_RATE_1600;
            {3'h1, 2'h3}, {3'h3, 2'h0}, {3'h4, 2'h0}: max_code = OFA_RATE_1000;
            {3'h2, 2'h1}, {3'h2, 2'h2}, {3'h3, 2'h1}: max_code = OFA_RATE_800;
            {3'h2, 2'h3}, {3'h3, 2'h2}, {3'h4, 2'h1}, {3'h4, 2'h2}: max_code = OFA_RATE_400;
            {3'h3, 2'h3}, {3'h4, 2'h3}: max_code = OFA_RATE_200;
            default: max_code = OFA_RATE_1000;
         endcase
      end else begin
         case (items)
            3'h1: max_code = OFA_DUAL_100;
            3'h2: max_code = lp_i ? OFA_DUAL_50 : ((tint_i < 2'h2) ? OFA_DUAL_100 : OFA_DUAL_84);
            3'h3: max_code = OFA_DUAL_50;
            3'h4: max_code = (lp_i || tint_i >= 2'h2) ? OFA_DUAL_25 : OFA_DUAL_50;
            default: max_code = OFA_DUAL_25;
         endcase
      end
   end

   // Evaluated every cycle, so a new setting is checked one cycle after it is written
   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         rate_eff_o <= OFA_CFG1_RST[OFA_RATE_LSB +: 4];
      end else begin
         rate_eff_o <= (rate_req_i > max_code) ? max_code : rate_req_i;
      end
   end

endmodule
`default_nettype wire

// ### ofa_timing_ctrl.sv
// Optical sampling engine control: power save, soft reset, rate clamping and pulse timing
// Contract
// - Writing one to the power-save bit enters a low-current state while all registers stay readable and writable.
// - While power save is active every interrupt flag is forced to zero.
// - Power save stops the oscillator and the conversion result keeps its last value.
// - A power-save request during a conversion takes effect only after that conversion finishes.
// - Writing one to the soft reset bit returns all configuration and data registers to power-on values.
// - The soft reset bit clears itself when the reset sequence completes, so software can poll it.
// - The two-bit range field selects the photodiode ADC scale from 6 uA to 48 uA full scale.
// - Rate codes 0000 to 1010 select single-pulse sampling from 20 to 3200 samples per second.
// - Rate codes 1011 to 1111 select dual-pulse sampling from 20 to 100 samples per second, two spaced pulses each.
// - An unsupported rate combination is replaced by the highest supported rate, shown on readback.
// - Single-pulse maximum rates follow the integration code and the number of data items.
// - Dual-pulse maximum rates follow the data items, integration code and low-power flag.
// - The integration field sets 52, 104, 206 or 417 us integration giving 16 to 19 bits.
// - The LED pulse width is the integration time plus the settling delay, LED on before integration.
// - The settling field delays integration after LED turn-on by 2.5, 5, 10 or 20 ms.
// - With the low-power flag set the device powers down between samples, only at 100 Hz and below.
`timescale 1ns/1ps
`default_nettype none
module ofa_timing_ctrl
   import ofa_pkg::*;
#(
   // Clock rate in MHz; lowering it shortens every time-based count in simulation
   parameter int unsigned CLK_MHZ = 100
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [2:0] item_count_i,
   input wire logic [18:0] adc_result_i,
   output logic [7:0] rdata_o,
   output logic [18:0] result_o,
   output logic led_on_o,
   output logic integrate_o,
   output logic sample_done_o,
   output logic osc_run_o,
   output logic irq_clear_o,
   output logic powerdown_o,
   output logic [1:0] photo_adc_range_o,
   output logic [4:0] resolution_o
);

   typedef struct packed {
      logic [7:0] sys;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [2:0] seq;
      ofa_state_e st;
      logic [31:0] period_cnt;
      logic [31:0] phase_cnt;
      logic second;
      logic [18:0] result;
      logic [7:0] rdata;
      logic led;
      logic integ;
      logic done;
      logic osc;
      logic irq_clr;
      logic pdown;
      logic [1:0] range;
      logic [4:0] res;
   } ofa_regs_s;

   ofa_regs_s r;
   ofa_regs_s next_r;
   ofa_regs_s rst_val;

   logic [3:0] rate_eff;
   logic soft_active;
   logic power_save;
   logic lp_flag;
   logic dual;
   logic slow_rate;
   logic [1:0] tint;
   logic [1:0] settle;
   logic [7:0] read_data;

   assign soft_active = (r.seq != 3'h0);
   assign power_save = r.sys[OFA_POWER_SAVE_BIT];
   assign lp_flag = r.sys[OFA_LP_BIT];
   assign tint = r.cfg1[OFA_TINT_LSB +: 2];
   assign settle = r.cfg2[OFA_SETTLE_LSB +: 2];
   assign dual = (rate_eff >= OFA_DUAL_FIRST);
   assign slow_rate = dual || (rate_eff <= OFA_RATE_100);

   ofa_rate_limit u_limit (
      .clk_i(clk_i),
      .clear_i(rst_i || soft_active),
      .rate_req_i(r.cfg1[OFA_RATE_LSB +: 4]),
      .tint_i(tint),
      .items_i(item_count_i),
      .lp_i(lp_flag),
      .rate_eff_o(rate_eff)
   );

   always_comb begin
      rst_val = '0;
      rst_val.sys = OFA_SYS_CTRL_RST;
      rst_val.cfg1 = OFA_CFG1_RST;
      rst_val.cfg2 = OFA_CFG2_RST;
      rst_val.st = OFA_ST_IDLE;
      rst_val.osc = 1'b1;
      rst_val.res = OFA_RES_BITS[0][4:0];
   end

   // Register reads answer one cycle later; unmapped offsets read zero
   always_comb begin
      read_data = r.rdata;
      if (rd_i) begin
         case (addr_i)
            OFA_SYS_CTRL_ADDR: read_data = r.sys;
            OFA_CFG1_ADDR: read_data = {r.cfg1[7:6], rate_eff, r.cfg1[1:0]};
            OFA_CFG2_ADDR: read_data = r.cfg2;
            default: read_data = 8'h00;
         endcase
      end
   end

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.rdata = read_data;

      // Writes act in every state, power save included, but are ignored while the soft reset sequence runs
      if (wr_i && !soft_active) begin
         case (addr_i)
            OFA_SYS_CTRL_ADDR: next_r.sys = wdata_i & OFA_SYS_CTRL_MASK;
            OFA_CFG1_ADDR: next_r.cfg1 = wdata_i;
            OFA_CFG2_ADDR: next_r.cfg2 = wdata_i & OFA_CFG2_MASK;
            default: next_r.cfg1 = r.cfg1;
         endcase
      end

      case (r.st)
         OFA_ST_IDLE: begin
            if (power_save) begin
               next_r.st = OFA_ST_SHUT;
            end else if (r.period_cnt <= 32'h1) begin
               next_r.period_cnt = ofa_period(rate_eff, CLK_MHZ);
               if (item_count_i != 3'h0) begin
                  next_r.st = OFA_ST_SETTLE;
                  next_r.second = 1'b0;
                  next_r.phase_cnt = ofa_cycles_up(OFA_SETTLE_NS[settle], CLK_MHZ);
                  next_r.led = 1'b1;
               end
            end else begin
               next_r.period_cnt = r.period_cnt - 32'h1;
            end
         end
         OFA_ST_SETTLE: begin
            next_r.period_cnt = r.period_cnt - 32'h1;
            if (r.phase_cnt <= 32'h1) begin
               next_r.st = OFA_ST_INTEG;
               next_r.integ = 1'b1;
               next_r.phase_cnt = ofa_cycles_up(OFA_TINT_NS[tint], CLK_MHZ);
            end else begin
               next_r.phase_cnt = r.phase_cnt - 32'h1;
            end
         end
         OFA_ST_INTEG: begin
            next_r.period_cnt = r.period_cnt - 32'h1;
            if (r.phase_cnt <= 32'h1) begin
               next_r.led = 1'b0;
               next_r.integ = 1'b0;
               if (dual && !r.second) begin
                  next_r.st = OFA_ST_GAP;
                  next_r.second = 1'b1;
                  next_r.phase_cnt = ofa_cycles_up(OFA_DUAL_GAP_NS, CLK_MHZ);
               end else begin
                  // Conversion always completes; a pending power save is taken in idle
                  next_r.st = OFA_ST_IDLE;
                  next_r.done = 1'b1;
                  // Keep only the bits the selected resolution provides
                  next_r.result = adc_result_i >> (OFA_MAX_RES_BITS - OFA_RES_BITS[tint]);
               end
            end else begin
               next_r.phase_cnt = r.phase_cnt - 32'h1;
            end
         end
         OFA_ST_GAP: begin
            next_r.period_cnt = r.period_cnt - 32'h1;
            if (r.phase_cnt <= 32'h1) begin
               next_r.st = OFA_ST_SETTLE;
               next_r.led = 1'b1;
               next_r.phase_cnt = ofa_cycles_up(OFA_SETTLE_NS[settle], CLK_MHZ);
            end else begin
               next_r.phase_cnt = r.phase_cnt - 32'h1;
            end
         end
         OFA_ST_SHUT: begin
            // Result stays frozen here; timing restarts with a full period on exit
            if (!power_save) begin
               next_r.st = OFA_ST_IDLE;
               next_r.period_cnt = ofa_period(rate_eff, CLK_MHZ);
            end
         end
         default: next_r.st = OFA_ST_IDLE;
      endcase

      next_r.osc = (next_r.st != OFA_ST_SHUT);
      next_r.irq_clr = next_r.sys[OFA_POWER_SAVE_BIT] || (next_r.st == OFA_ST_SHUT);
      // Dynamic power-down is refused at rates above 100 Hz
      next_r.pdown = next_r.sys[OFA_LP_BIT] && slow_rate && (next_r.st == OFA_ST_IDLE);
      next_r.range = next_r.cfg1[OFA_RANGE_LSB +: 2];
      next_r.res = OFA_RES_BITS[next_r.cfg1[OFA_TINT_LSB +: 2]][4:0];

      // Soft reset: registers held at power-on values while the bit reads back one
      if (soft_active) begin
         next_r = rst_val;
         // Read data survives the sequence, otherwise the reset bit could never be polled
         next_r.rdata = read_data;
         next_r.seq = r.seq - 3'h1;
         next_r.sys[OFA_SOFT_RESET_BIT] = (r.seq != 3'h1);
      end else if (wr_i && addr_i == OFA_SYS_CTRL_ADDR && wdata_i[OFA_SOFT_RESET_BIT]) begin
         next_r = rst_val;
         next_r.rdata = read_data;
         next_r.seq = OFA_RESET_SEQ_CYCLES;
         next_r.sys[OFA_SOFT_RESET_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= rst_val;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o = r.rdata;
   assign result_o = r.result;
   assign led_on_o = r.led;
   assign integrate_o = r.integ;
   assign sample_done_o = r.done;
   assign osc_run_o = r.osc;
   assign irq_clear_o = r.irq_clr;
   assign powerdown_o = r.pdown;
   assign photo_adc_range_o = r.range;
   assign resolution_o = r.res;

endmodule
`default_nettype wire

// ### ofa_timing_ctrl_asserts.sv
// Port checker for the optical sampling timing control
`timescale 1ns/1ps
`default_nettype none
module ofa_timing_ctrl_asserts
   import ofa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [18:0] result_o,
   input wire logic led_on_o,
   input wire logic integrate_o,
   input wire logic sample_done_o,
   input wire logic osc_run_o,
   input wire logic irq_clear_o,
   input wire logic powerdown_o,
   input wire logic [1:0] photo_adc_range_o,
   input wire logic [4:0] resolution_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_integ_led_on: assert property (integrate_o |-> led_on_o)
      else $error("integration without LED");
   chk_led_first: assert property ($rose(integrate_o) |-> $past(led_on_o))
      else $error("integration began before LED");
   chk_done_pulse: assert property (sample_done_o |=> !sample_done_o)
      else $error("sample done longer than one cycle");
   chk_done_quiet: assert property (sample_done_o |-> !integrate_o && !led_on_o)
      else $error("sample done during a pulse");
   chk_shut_quiet: assert property (!osc_run_o |-> irq_clear_o && !led_on_o && !integrate_o)
      else $error("activity or flags while shut down");
   chk_result_hold: assert property (!osc_run_o ##1 !osc_run_o |-> $stable(result_o))
      else $error("result changed while shut down");
   chk_shut_after: assert property ($fell(osc_run_o) |-> !$past(led_on_o) && !$past(integrate_o))
      else $error("shut down cut a conversion");
   chk_pdown_idle: assert property (powerdown_o |-> !led_on_o && !integrate_o)
      else $error("powered down during a pulse");
   chk_rd_unmapped: assert property (rd_i && !(addr_i inside {8'h0D, 8'h0E, 8'h0F}) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_cfg_fields: assert property (rd_i && !wr_i && addr_i == 8'h0E |=>
      rdata_o[7:6] == photo_adc_range_o && rdata_o[1:0] == resolution_o[1:0])
      else $error("range or resolution differs from readback");
   chk_res_span: assert property (resolution_o >= 5'h10 && resolution_o <= 5'h13)
      else $error("resolution out of span");
   cov_done: cover property (sample_done_o);
   cov_shut: cover property ($fell(osc_run_o));
   cov_pdown: cover property (powerdown_o);
endmodule
bind ofa_timing_ctrl ofa_timing_ctrl_asserts ofa_timing_ctrl_asserts_inst (.clk_i, .rst_i, .addr_i,
   .wr_i, .rd_i, .rdata_o, .result_o, .led_on_o, .integrate_o, .sample_done_o, .osc_run_o,
   .irq_clear_o, .powerdown_o, .photo_adc_range_o, .resolution_o);
`default_nettype wire

// ### ofa_timing_ctrl_tb_top.sv
// Self-checking bench for the optical sampling timing control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module ofa_timing_ctrl_tb_top;
   import ofa_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, lp;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v, c;
   logic [2:0] item_count_i = 3'h0;
   logic [18:0] adc_result_i = 19'h0, result_o, r;
   logic led_on_o, integrate_o, sample_done_o, osc_run_o, irq_clear_o, powerdown_o;
   logic [1:0] photo_adc_range_o;
   logic [4:0] resolution_o;
   int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 91157, i, n;
   always #5 clk_i = ~clk_i;
   // One MHz keeps the 2.5 ms settle at 2500 cycles
   ofa_timing_ctrl #(.CLK_MHZ(1)) ofa_timing_ctrl_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .item_count_i, .adc_result_i, .rdata_o, .result_o, .led_on_o, .integrate_o, .sample_done_o,
      .osc_run_o, .irq_clear_o, .powerdown_o, .photo_adc_range_o, .resolution_o);
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      tick(1);
      wr_i = 1'b0;
      // An idle edge keeps two strobes of one kind apart
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a);
      addr_i = a;
      rd_i = 1'b1;
      tick(1);
      rd_i = 1'b0;
      v = rdata_o;
      tick(1);
   endtask
   // Requested code capped at the highest supported code in the same pulse mode; zero items counts as one
   function automatic logic [3:0] lim(input logic [3:0] q, input logic [1:0] t, input logic [2:0] k,
      input logic p);
      logic [63:0] sg;
      logic [3:0] m;
      int j;
      sg = 64'h5668_5678_6779_899A;
      j = (k == 3'h0) ? 0 : int'(k) - 1;
      if (q <= 4'hA) begin
         m = sg[j * 16 + int'(t) * 4 +: 4];
      end else begin
         case (j)
            0: m = 4'hF;
            1: m = p ? 4'hD : (t < 2'h2 ? 4'hF : 4'hE);
            2: m = 4'hD;
            default: m = (p || t > 2'h1) ? 4'hC : 4'hD;
         endcase
      end
      return (q > m) ? m : q;
   endfunction
   initial begin
      tick(3);
      rst_i = 1'b0;
      `CHK(resolution_o, 5'h10)
      wr(8'h20, 8'h5A);
      for (i = 0; i < 4; i++) begin
         rd(8'h0D + 8'(i));
         `CHK(v, (i == 2) ? 8'h18 : 8'h00)
      end
      wr(8'h0F, 8'hFF);
      rd(8'h0F);
      `CHK(v, 8'h1F)
      for (i = 0; i < 48; i++) begin
         lp = 1'($random(seed));
         item_count_i = 3'($unsigned($random(seed)) % 5);
         c = 8'($random(seed));
         c[5:2] = 4'(i);
         wr(8'h0D, {4'h0, lp, 3'h0});
         wr(8'h0E, c);
         tick(1);
         rd(8'h0E);
         `CHK(v, {c[7:6], lim(c[5:2], c[1:0], item_count_i, lp), c[1:0]})
         `CHK(photo_adc_range_o, c[7:6])
         `CHK(resolution_o, 5'h10 + 5'(c[1:0]))
      end
      item_count_i = 3'h0;
      wr(8'h0D, 8'h01);
      // Lands inside the reset sequence, so it must be lost
      wr(8'h0F, 8'h07);
      rd(8'h0D);
      `CHK(v[0], 1'b1)
      for (n = 0; n < 10 && v[0]; n++) begin
         rd(8'h0D);
      end
      `CHK(v, 8'h00)
      rd(8'h0E);
      `CHK(v, 8'h00)
      rd(8'h0F);
      `CHK(v, 8'h18)
      wr(8'h0F, 8'h00);
      wr(8'h0E, 8'h10);
      adc_result_i = 19'($random(seed));
      r = adc_result_i >> 3;
      item_count_i = 3'h1;
      // Power save and back restarts the sample period at the new rate
      wr(8'h0D, 8'h02);
      wr(8'h0D, 8'h00);
      for (n = 0; n < 12000 && !led_on_o; n++) tick(1);
      for (n = 0; n < 9999 && !integrate_o; n++) tick(1);
      `CHK(n, OFA_SETTLE_NS[0] / 1000)
      tick(10);
      `CHK(led_on_o, 1'b1)
      wr(8'h0D, 8'h02);
      `CHK(osc_run_o, 1'b1)
      for (n = 0; n < 200 && integrate_o; n++) tick(1);
      `CHK(n + 12, OFA_TINT_NS[0] / 1000)
      for (n = 0; n < 5 && !sample_done_o; n++) tick(1);
      `CHK(sample_done_o, 1'b1)
      `CHK(result_o, r)
      tick(2);
      `CHK(osc_run_o, 1'b0)
      `CHK(irq_clear_o, 1'b1)
      adc_result_i = ~adc_result_i;
      wr(8'h0E, 8'hC6);
      rd(8'h0E);
      `CHK(v, 8'hC6)
      tick(20);
      `CHK(result_o, r)
      wr(8'h0E, 8'h10);
      wr(8'h0D, 8'h08);
      tick(2);
      `CHK(osc_run_o, 1'b1)
      `CHK(irq_clear_o, 1'b0)
      for (n = 0; n < 14000 && !sample_done_o; n++) tick(1);
      tick(3);
      `CHK(powerdown_o, 1'b1)
      wr(8'h0E, 8'h14);
      tick(3);
      `CHK(powerdown_o, 1'b0)
      end_sim();
   end
endmodule
`default_nettype wire
